// ---- dbg_pkg.sv ----
/*
  Constants for the debug pin and error flag block: register offsets, field positions,
  pin source selections and reset values.
  Assumes a simple strobe register port and a single clock domain.
*/
package dbg_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // register offsets (byte addresses, one word each)
  localparam logic [ADDR_W-1:0] OFS_PIN_CFG  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OUT_PINS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_MASK     = 4'hC;

  // pin configuration: per pin a 4-bit field at 4*i
  // bits [2:0] source select, bit [3] output enable
  localparam int unsigned NUM_DBG_PINS = 3;
  localparam int unsigned CFG_FIELD_W  = 4;
  localparam int unsigned CFG_SEL_W    = 3;
  localparam int unsigned CFG_OE_BIT   = 3;
  // software output level of debug pins at bits [18:16]
  localparam int unsigned CFG_LVL_POS  = 16;

  localparam logic [CFG_SEL_W-1:0] SEL_SOFT   = 3'h0;
  localparam logic [CFG_SEL_W-1:0] SEL_TX_EN  = 3'h1;
  localparam logic [CFG_SEL_W-1:0] SEL_RX_DV  = 3'h2;
  localparam logic [CFG_SEL_W-1:0] SEL_TX_CLK = 3'h3;
  localparam logic [CFG_SEL_W-1:0] SEL_RX_CLK = 3'h4;

  // output-only pins: bit 0 -> three, bit 1 -> four
  localparam int unsigned NUM_OUT_PINS = 2;

  // error flag positions in status and mask
  localparam int unsigned NUM_FLAGS      = 6;
  localparam int unsigned FLG_RX_MISUSE  = 0;
  localparam int unsigned FLG_TX_MISUSE  = 1;
  localparam int unsigned FLG_TX_STS_FUL = 2;
  localparam int unsigned FLG_RX_STS_FUL = 3;
  localparam int unsigned FLG_TX_STS_OVF = 4;
  localparam int unsigned FLG_TX_DAT_OVR = 5;

  localparam logic [DATA_W-1:0]    RST_PIN_CFG  = 32'h0000_0000;
  localparam logic [NUM_OUT_PINS-1:0] RST_OUT_PINS = 2'h0;
  localparam logic [NUM_FLAGS-1:0] RST_MASK     = 6'h00;

  // synchroniser depth for pin and foreign-clock inputs
  localparam int unsigned SYNC_STAGES = 2;

endpackage

// ---- dbg_sync.sv ----
/*
  Two-flop synchroniser for a bus of asynchronous levels.
  Assumes the caller reads only the output; the first stage feeds the second alone.
*/
`timescale 1ns/1ps
module dbg_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ---- dbg_pins.sv ----
/*
  Debug observation pins and error flags: three configurable debug pins, two output-only
  pins, sticky error status with mask and an active-low interrupt output.
  Assumes MAC signals and media clocks arrive asynchronous to mclk and are synchronised
  here; error events come as one-cycle pulses already on mclk.
*/
// Our own choices: the placing of the registers and the plain strobed port.
// Contract
// R1: three debug pins, each software configurable
// R2: two output-only pins follow software level
// R3: debug pin can carry transmit enable
// R4: debug pin can carry receive data valid
// R5: media transmit/receive clocks routable to pins
// R6: FIFO misuse raises rx/tx error flag
// R7: transmit status FIFO full raises flag
// R8: receive status FIFO full raises flag
// R9: flags sticky until cleared; mask gates interrupt
`timescale 1ns/1ps
module dbg_pins
  import dbg_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  // register port
  input  wire logic [ADDR_W-1:0]       reg_addr,
  input  wire logic [DATA_W-1:0]       reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [DATA_W-1:0]       reg_rdata,
  // MAC observation sources (asynchronous to mclk)
  input  wire logic                    mac_tx_en,
  input  wire logic                    mac_rx_dv,
  input  wire logic                    media_tx_clk,
  input  wire logic                    media_rx_clk,
  // error events, one-cycle pulses on mclk
  input  wire logic                    rx_misuse_evt,
  input  wire logic                    tx_misuse_evt,
  input  wire logic                    tx_status_full_evt,
  input  wire logic                    rx_status_full_evt,
  input  wire logic                    tx_status_overflow_evt,
  input  wire logic                    tx_data_overrun_evt,
  // debug pins, two-way
  input  wire logic                    debug_pin_one_in,
  output logic                         debug_pin_one_out,
  output logic                         debug_pin_one_oe,
  input  wire logic                    debug_pin_two_in,
  output logic                         debug_pin_two_out,
  output logic                         debug_pin_two_oe,
  input  wire logic                    debug_pin_extra_in,
  output logic                         debug_pin_extra_out,
  output logic                         debug_pin_extra_oe,
  // output-only pins
  output logic                         output_pin_three,
  output logic                         output_pin_four,
  output logic                         interrupt_out_n
);

  logic [DATA_W-1:0]       pin_cfg;
  logic [NUM_OUT_PINS-1:0] out_pins;
  logic [NUM_FLAGS-1:0]    status;
  logic [NUM_FLAGS-1:0]    mask;

  // synchronised sources: tx_en, rx_dv, tx_clk, rx_clk
  logic [3:0] src_sync;
  // synchronised pin input levels
  logic [NUM_DBG_PINS-1:0] pin_in_sync;

  dbg_sync #(
    .WIDTH(4)
  ) u_src_sync (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .async_in({media_rx_clk, media_tx_clk, mac_rx_dv, mac_tx_en}),
    .sync_out(src_sync)
  );

  dbg_sync #(
    .WIDTH(NUM_DBG_PINS)
  ) u_pin_sync (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .async_in({debug_pin_extra_in, debug_pin_two_in, debug_pin_one_in}),
    .sync_out(pin_in_sync)
  );

  // register decode
  wire wr_cfg    = reg_wr && (reg_addr == OFS_PIN_CFG);
  wire wr_out    = reg_wr && (reg_addr == OFS_OUT_PINS);
  wire wr_status = reg_wr && (reg_addr == OFS_STATUS);
  wire wr_mask   = reg_wr && (reg_addr == OFS_MASK);

  // status read shows flags; pin read shows live synchronised inputs in bits [2:0]
  wire [DATA_W-1:0] rd_cfg_word =
    {pin_cfg[DATA_W-1:8], 5'h00, pin_in_sync};
  wire [DATA_W-1:0] rd_mux =
    (reg_addr == OFS_PIN_CFG)  ? rd_cfg_word :
    (reg_addr == OFS_OUT_PINS) ? {{(DATA_W-NUM_OUT_PINS){1'b0}}, out_pins} :
    (reg_addr == OFS_STATUS)   ? {{(DATA_W-NUM_FLAGS){1'b0}}, status} :
    (reg_addr == OFS_MASK)     ? {{(DATA_W-NUM_FLAGS){1'b0}}, mask} :
                                 {DATA_W{1'b0}};

  // event vector in flag order
  wire [NUM_FLAGS-1:0] evt = {
    tx_data_overrun_evt,     // FLG_TX_DAT_OVR
    tx_status_overflow_evt,  // FLG_TX_STS_OVF
    rx_status_full_evt,      // [R8]
    tx_status_full_evt,      // [R7]
    tx_misuse_evt,           // [R6]
    rx_misuse_evt            // [R6]
  };

  // set wins over a write-one clear in the same cycle
  wire [NUM_FLAGS-1:0] clr = wr_status ? reg_wdata[NUM_FLAGS-1:0] : {NUM_FLAGS{1'b0}};
  wire [NUM_FLAGS-1:0] next_status = (status & ~clr) | evt;  // [R9]
  wire next_irq_n = ~|(next_status & (wr_mask ? reg_wdata[NUM_FLAGS-1:0] : mask));  // [R9]

  // per-pin source select and drive
  logic [NUM_DBG_PINS-1:0] next_pin_out;
  logic [NUM_DBG_PINS-1:0] next_pin_oe;
  logic [DATA_W-1:0]       next_cfg;
  assign next_cfg = wr_cfg ? reg_wdata : pin_cfg;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DBG_PINS; gi++) begin : g_pin
      wire [CFG_SEL_W-1:0] sel = next_cfg[gi*CFG_FIELD_W +: CFG_SEL_W];  // [R1]
      wire soft_lvl = next_cfg[CFG_LVL_POS + gi];
      assign next_pin_oe[gi] = next_cfg[gi*CFG_FIELD_W + CFG_OE_BIT];   // [R1]
      assign next_pin_out[gi] =
        (sel == SEL_TX_EN)  ? src_sync[0] :   // [R3]
        (sel == SEL_RX_DV)  ? src_sync[1] :   // [R4]
        (sel == SEL_TX_CLK) ? src_sync[2] :   // [R5]
        (sel == SEL_RX_CLK) ? src_sync[3] :   // [R5]
                              soft_lvl;
    end
  endgenerate

  wire [NUM_OUT_PINS-1:0] next_out_pins =
    wr_out ? reg_wdata[NUM_OUT_PINS-1:0] : out_pins;  // [R2]

  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_cfg  <= RST_PIN_CFG;
      out_pins <= RST_OUT_PINS;
      mask     <= RST_MASK;
      status   <= '0;
    end else if (ce) begin
      pin_cfg  <= next_cfg;
      out_pins <= next_out_pins;
      status   <= next_status;
      if (wr_mask) begin
        mask <= reg_wdata[NUM_FLAGS-1:0];
      end
    end
  end

  // outputs straight from flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata           <= '0;
      debug_pin_one_out   <= 1'b0;
      debug_pin_two_out   <= 1'b0;
      debug_pin_extra_out <= 1'b0;
      debug_pin_one_oe    <= 1'b0;
      debug_pin_two_oe    <= 1'b0;
      debug_pin_extra_oe  <= 1'b0;
      output_pin_three    <= 1'b0;
      output_pin_four     <= 1'b0;
      interrupt_out_n     <= 1'b1;
    end else if (ce) begin
      reg_rdata           <= reg_rd ? rd_mux : '0;
      debug_pin_one_out   <= next_pin_out[0];
      debug_pin_two_out   <= next_pin_out[1];
      debug_pin_extra_out <= next_pin_out[2];
      debug_pin_one_oe    <= next_pin_oe[0];
      debug_pin_two_oe    <= next_pin_oe[1];
      debug_pin_extra_oe  <= next_pin_oe[2];
      output_pin_three    <= next_out_pins[0];  // [R2]
      output_pin_four     <= next_out_pins[1];  // [R2]
      interrupt_out_n     <= next_irq_n;         // [R9]
    end
  end

endmodule

// ---- dbg_pins_asserts.sv ----
/*
  Checker for dbg_pins: read answer, output pins, sticky interrupt, source routing.
  Assumes it is bound to dbg_pins and every event pulse is on mclk.
*/
`timescale 1ns/1ps
module dbg_pins_asserts
  import dbg_pkg::*;
(
  input wire logic              mclk, rst, ce, reg_wr, reg_rd, mac_tx_en, mac_rx_dv,
  input wire logic              rx_misuse_evt, tx_misuse_evt,
  input wire logic              tx_status_full_evt, rx_status_full_evt,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata, reg_rdata,
  input wire logic              output_pin_three, output_pin_four, interrupt_out_n,
  input wire logic              debug_pin_one_out, debug_pin_two_out
);
  logic [7:0] cfg_sh;
  logic [5:0] msk_sh;
  wire        wr_cfg = ce && reg_wr && reg_addr == OFS_PIN_CFG;
  wire        wr_msk = ce && reg_wr && reg_addr == OFS_MASK;
  wire        wr_sts = ce && reg_wr && reg_addr == OFS_STATUS;
  // shadow copies, since the checker sees ports only
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_sh <= 8'h00;
      msk_sh <= 6'h00;
    end else begin
      if (wr_cfg) cfg_sh <= reg_wdata[7:0];
      if (wr_msk) msk_sh <= reg_wdata[5:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_out_pins_follow: assert property ($past(ce && reg_wr && reg_addr == OFS_OUT_PINS)
    |-> {output_pin_four, output_pin_three} == $past(reg_wdata[1:0]))
    else $error("output pins differ from written level");
  a_mask_zero_quiet: assert property ($past(wr_msk && reg_wdata[5:0] == 6'h00)
    |-> interrupt_out_n) else $error("interrupt with all masked");
  a_irq_sticky_low: assert property (!interrupt_out_n && !wr_msk && !wr_sts
    |=> !interrupt_out_n) else $error("interrupt dropped without clear");
  a_misuse_irq_low: assert property ((rx_misuse_evt && msk_sh[0] || tx_misuse_evt
    && msk_sh[1]) && !wr_msk |=> !interrupt_out_n) else $error("misuse gave no interrupt");
  a_full_irq_low: assert property ((tx_status_full_evt && msk_sh[2] ||
    rx_status_full_evt && msk_sh[3]) && !wr_msk |=> !interrupt_out_n)
    else $error("status full gave no interrupt");
  a_pin_one_txen: assert property (cfg_sh[3:0] == 4'h9 && $past(cfg_sh[3:0], 3) == 4'h9
    |-> debug_pin_one_out == $past(mac_tx_en, 3)) else $error("pin one not transmit enable");
  a_pin_two_rxdv: assert property (cfg_sh[7:4] == 4'hA && $past(cfg_sh[7:4], 3) == 4'hA
    |-> debug_pin_two_out == $past(mac_rx_dv, 3)) else $error("pin two not receive valid");
endmodule
bind dbg_pins dbg_pins_asserts u_dbg_pins_asserts (.*);

// ---- dbg_mac_model.sv ----
/*
  Far-side model: free-running media clocks and packet envelopes.
  Assumes the bench holds tx_go or rx_go for the length of each packet.
*/
`timescale 1ns/1ps
module dbg_mac_model (
  input  wire logic tx_go,
  input  wire logic rx_go,
  output logic      media_tx_clk,
  output logic      media_rx_clk,
  output logic      mac_tx_en,
  output logic      mac_rx_dv
);
  // 25 MHz, edges kept off the mclk rising edges
  initial begin
    media_tx_clk = 1'b0;
    forever #20 media_tx_clk = ~media_tx_clk;
  end
  initial begin
    media_rx_clk = 1'b0;
    #3;
    forever #20 media_rx_clk = ~media_rx_clk;
  end
  always @(posedge media_tx_clk) mac_tx_en <= tx_go;
  always @(posedge media_rx_clk) mac_rx_dv <= rx_go;
endmodule

// ---- dbg_pins_bench.sv ----
/*
  Self-checking bench for dbg_pins: registers, pins, routing, flags, interrupt.
  Assumes dbg_mac_model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module dbg_pins_bench
  import dbg_pkg::*;
;
  logic              mclk, rst, reg_wr, reg_rd, tx_go, rx_go;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, d;
  logic [5:0]        evt;
  logic [2:0]        ext;
  int                n_mismatch = 0;
  int                n_checks = 0;
  wire logic [DATA_W-1:0] reg_rdata;
  wire logic mac_tx_en, mac_rx_dv, media_tx_clk, media_rx_clk, interrupt_out_n;
  wire logic output_pin_three, output_pin_four, debug_pin_one_out, debug_pin_one_oe;
  wire logic debug_pin_two_out, debug_pin_two_oe, debug_pin_extra_out, debug_pin_extra_oe;
  // pin level: module drive wins over the outside level
  wire logic [2:0] pin = {debug_pin_extra_oe ? debug_pin_extra_out : ext[2],
    debug_pin_two_oe ? debug_pin_two_out : ext[1], debug_pin_one_oe ? debug_pin_one_out : ext[0]};
  dbg_pins u_dbg_pins (.*, .ce(1'b1), .rx_misuse_evt(evt[0]), .tx_misuse_evt(evt[1]),
    .tx_status_full_evt(evt[2]), .rx_status_full_evt(evt[3]), .tx_status_overflow_evt(evt[4]),
    .tx_data_overrun_evt(evt[5]), .debug_pin_one_in(pin[0]), .debug_pin_two_in(pin[1]),
    .debug_pin_extra_in(pin[2]));
  dbg_mac_model u_dbg_mac_model (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic pulse(input int i);
    @(posedge mclk);
    evt <= 6'(1 << i);
    @(posedge mclk);
    evt <= 6'h00;
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // reset values, unmapped offsets read zero
  task automatic t_reset;
    // pin inputs need two synchroniser edges after reset before they read back
    repeat (2) @(posedge mclk);
    for (int a = 0; a < 16; a += 2) begin
      rd(4'(a));
      check(d, (a == 0) ? {29'h0, ext} : 32'h0);
    end
    check({interrupt_out_n, debug_pin_one_oe, debug_pin_two_oe, debug_pin_extra_oe}, 4'h8);
  endtask
  task automatic t_out_pins;
    for (int v = 0; v < 4; v++) begin
      wr(OFS_OUT_PINS, 32'(v));
      check({output_pin_four, output_pin_three}, 32'(v));
    end
  endtask
  task automatic t_soft_pins;
    wr(OFS_PIN_CFG, 32'h0005_0888);
    check({debug_pin_extra_out, debug_pin_two_out, debug_pin_one_out}, 3'h5);
    check({debug_pin_extra_oe, debug_pin_two_oe, debug_pin_one_oe}, 3'h7);
    wr(OFS_PIN_CFG, 32'h0002_0888);
    repeat (3) @(posedge mclk);
    rd(OFS_PIN_CFG);
    check(d, 32'h0002_0802);
  endtask
  task automatic t_sources;
    int cnt;
    wr(OFS_PIN_CFG, 32'h0000_0BA9);
    tx_go <= 1'b1;
    repeat (20) @(posedge mclk);
    check({debug_pin_two_out, debug_pin_one_out}, 2'h1);
    tx_go <= 1'b0;
    rx_go <= 1'b1;
    repeat (20) @(posedge mclk);
    check({debug_pin_two_out, debug_pin_one_out}, 2'h2);
    rx_go <= 1'b0;
    // 2 us at 25 MHz is 50 rising edges on the extra pin
    for (int s = 3; s < 5; s++) begin
      wr(OFS_PIN_CFG, 32'h0000_08A9 | 32'(s) << 8);
      cnt = 0;
      fork
        repeat (200) @(posedge mclk);
        forever @(posedge debug_pin_extra_out) cnt++;
      join_any
      disable fork;
      check(cnt >= 49 && cnt <= 51, 1'b1);
    end
  endtask
  task automatic t_flags;
    for (int i = 0; i < 6; i++) begin
      wr(OFS_MASK, 32'h0);
      pulse(i);
      check(interrupt_out_n, 1'b1);
      rd(OFS_STATUS);
      check(d, 32'(1 << i));
      wr(OFS_MASK, 32'h3F);
      check(interrupt_out_n, 1'b0);
      wr(OFS_STATUS, 32'(1 << i));
      check(interrupt_out_n, 1'b1);
      pulse(i);
      check(interrupt_out_n, 1'b0);
      wr(OFS_STATUS, 32'(1 << i));
    end
  endtask
  initial begin
    {rst, reg_wr, reg_rd, tx_go, rx_go, reg_addr, reg_wdata, evt} = '0;
    rst = 1'b1;
    ext = 3'h5;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_out_pins;
    t_soft_pins;
    t_sources;
    t_flags;
    report_and_stop;
  end
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
